// *** rtl/isam_pkg.sv ***
`default_nettype none
package isam_pkg;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam int            ADDR_W      = 5;
  localparam int            DATA_W      = 16;
  localparam logic [4:0]    OFS_STATUS  = 5'h00;
  localparam logic [4:0]    OFS_MASK    = 5'h04;
  localparam logic [4:0]    OFS_RXH     = 5'h08;
  localparam logic [4:0]    OFS_TXH     = 5'h0C;
  localparam logic [4:0]    OFS_SADDR   = 5'h10;
  localparam logic [4:0]    OFS_CTRL    = 5'h14;
  localparam logic [4:0]    OFS_IRQ_ST  = 5'h18;
  localparam logic [4:0]    OFS_IRQ_MSK = 5'h1C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int ST_TBF   = 0;
  localparam int ST_RBF   = 1;
  localparam int ST_RW    = 2;
  localparam int ST_START = 3;
  localparam int ST_STOP  = 4;
  localparam int ST_DA    = 5;
  localparam int ST_ACK   = 15;
  localparam int CTRL_EN  = 0;
  localparam int EV_RX    = 0;
  localparam int EV_TX    = 1;
  localparam int EV_START = 2;
  localparam int EV_STOP  = 3;
  localparam int EV_MATCH = 4;
  localparam int NEV      = 5;

  // ****************************************
  // reset values and counts
  // ****************************************
  localparam int         MASK_W    = 10;
  localparam logic [9:0] MASK_RST  = 10'h000;
  localparam logic [6:0] SADDR_RST = 7'h2A;
  localparam logic       EN_RST    = 1'b0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT  = 4'h7;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [5:0] {
    PH_IDLE = 6'h01,
    PH_ADDR = 6'h02,
    PH_RX   = 6'h04,
    PH_TX   = 6'h08,
    PH_AACK = 6'h10,
    PH_MACK = 6'h20
  } isam_phase_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } isam_bus_t;

  typedef struct packed {
    logic             scl_s1;
    logic             scl_s2;
    logic             scl_p;
    logic             sda_s1;
    logic             sda_s2;
    logic             sda_p;
    isam_phase_t      phase;
    logic [3:0]       bitcnt;
    logic [7:0]       sh;
    logic [7:0]       txsh;
    logic [7:0]       rxh;
    logic [7:0]       txh;
    logic [9:0]       msk;
    logic [6:0]       saddr;
    logic             en;
    logic             da;
    logic             p;
    logic             s;
    logic             rw;
    logic             rx_holding_full;
    logic             tx_holding_full;
    logic             acknowledge_status_flag;
    logic [NEV-1:0]   irqst;
    logic [NEV-1:0]   imsk;
    logic             irq;
    logic             oe;
    logic             drv;
    logic [15:0]      rdata;
  } isam_state_t;

endpackage
`default_nettype wire

// *** rtl/isam_status_mask.sv ***
`timescale 1ns/1ns
`default_nettype none
module isam_status_mask #(
  parameter logic [6:0] SADDR_INIT = isam_pkg::SADDR_RST
) (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               ce,
  // register port
  input  wire isam_pkg::isam_bus_t bus,
  output logic [15:0]             rdata,
  output logic                    irq,
  // two-wire link pins
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe
);

  // ****************************************
  // state
  // ****************************************
  localparam isam_pkg::isam_state_t RST_STATE = '{
    scl_s1: 1'b1, scl_s2: 1'b1, scl_p: 1'b1,
    sda_s1: 1'b1, sda_s2: 1'b1, sda_p: 1'b1,
    phase: isam_pkg::PH_IDLE, bitcnt: 4'h0, sh: 8'h00, txsh: 8'h00,
    rxh: 8'h00, txh: 8'h00, msk: isam_pkg::MASK_RST, saddr: SADDR_INIT,
    en: isam_pkg::EN_RST, da: 1'b0, p: 1'b0, s: 1'b0, rw: 1'b0,
    rx_holding_full: 1'b0, tx_holding_full: 1'b0, acknowledge_status_flag: 1'b0, irqst: '0, imsk: '0,
    irq: 1'b0, oe: 1'b0, drv: 1'b0, rdata: 16'h0000
  };

  isam_pkg::isam_state_t q;
  isam_pkg::isam_state_t d;

  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;
  logic match;
  logic rx_set;
  logic tx_done;
  logic rd_rx;
  logic wr_tx;

  if (isam_pkg::MASK_W != 10 || isam_pkg::DATA_W != 16) begin : g_chk
    $error("isam_status_mask supports only a 10-bit mask on a 16-bit port");
  end

  // ****************************************
  // link conditions, from synchronised pins
  // ****************************************
  assign rise    = q.scl_s2 & ~q.scl_p;
  assign fall    = ~q.scl_s2 & q.scl_p;
  // sda may only move while scl is low, so a change with scl high is a condition
  assign start_c = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
  assign stop_c  = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
  // 7-bit addressing: mask bits 9..7 have nothing to line up with
  assign match   = (((q.sh[7:1] ^ q.saddr) & ~q.msk[6:0]) == 7'h00);
  assign rd_rx   = bus.rd && bus.addr == isam_pkg::OFS_RXH;
  assign wr_tx   = bus.wr && bus.addr == isam_pkg::OFS_TXH;
  assign rx_set  = q.en && q.phase == isam_pkg::PH_RX && rise && q.bitcnt == isam_pkg::LAST_BIT;
  assign tx_done = q.en && q.phase == isam_pkg::PH_MACK && rise;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [isam_pkg::NEV-1:0] ev;
    ev       = '0;
    d        = q;
    d.scl_s1 = scl_in;
    d.scl_s2 = q.scl_s1;
    d.scl_p  = q.scl_s2;
    d.sda_s1 = sda_in;
    d.sda_s2 = q.sda_s1;
    d.sda_p  = q.sda_s2;
    d.drv    = 1'b0;
    d.rdata  = 16'h0000;

    if (q.en) begin
      case (q.phase)
        isam_pkg::PH_ADDR, isam_pkg::PH_RX: begin
          if (rise && q.bitcnt < isam_pkg::BYTE_BITS) begin
            d.sh     = {q.sh[6:0], q.sda_s2};
            d.bitcnt = q.bitcnt + 4'h1;
            if (rx_set) begin
              d.rxh = {q.sh[6:0], q.sda_s2};
              d.da  = 1'b1;
            end
          end else if (fall && q.bitcnt == isam_pkg::BYTE_BITS) begin
            if (q.phase == isam_pkg::PH_RX) begin
              d.oe    = 1'b1;
              d.phase = isam_pkg::PH_AACK;
            end else if (match) begin
              d.rw           = q.sh[0];
              d.da           = 1'b0;
              d.oe           = 1'b1;
              d.phase        = isam_pkg::PH_AACK;
              ev[isam_pkg::EV_MATCH] = 1'b1;
            end else begin
              d.phase = isam_pkg::PH_IDLE;
            end
          end
        end
        isam_pkg::PH_AACK: begin
          if (fall) begin
            d.bitcnt = 4'h0;
            if (q.rw) begin
              d.txsh  = q.txh;
              d.oe    = ~q.txh[7];
              d.phase = isam_pkg::PH_TX;
            end else begin
              d.oe    = 1'b0;
              d.phase = isam_pkg::PH_RX;
            end
          end
        end
        isam_pkg::PH_TX: begin
          if (rise && q.bitcnt < isam_pkg::BYTE_BITS) begin
            d.txsh   = {q.txsh[6:0], 1'b0};
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (fall) begin
            if (q.bitcnt == isam_pkg::BYTE_BITS) begin
              d.oe    = 1'b0;
              d.phase = isam_pkg::PH_MACK;
            end else begin
              d.oe = ~q.txsh[7];
            end
          end
        end
        isam_pkg::PH_MACK: begin
          if (rise) begin
            d.acknowledge_status_flag = q.sda_s2;
            ev[isam_pkg::EV_TX] = 1'b1;
          end else if (fall) begin
            d.bitcnt = 4'h0;
            // a refused byte ends the read; wait for the next start
            if (q.acknowledge_status_flag) begin
              d.phase = isam_pkg::PH_IDLE;
            end else begin
              d.txsh  = q.txh;
              d.oe    = ~q.txh[7];
              d.phase = isam_pkg::PH_TX;
            end
          end
        end
        isam_pkg::PH_IDLE: begin
          d.oe = 1'b0;
        end
        default: begin
          d.oe    = 1'b0;
          d.phase = isam_pkg::PH_IDLE;
        end
      endcase
    end else begin
      d.oe    = 1'b0;
      d.phase = isam_pkg::PH_IDLE;
    end

    if (start_c) begin
      d.s      = 1'b1;
      d.p      = 1'b0;
      d.bitcnt = 4'h0;
      d.oe     = 1'b0;
      d.phase  = q.en ? isam_pkg::PH_ADDR : isam_pkg::PH_IDLE;
      ev[isam_pkg::EV_START] = 1'b1;
    end else if (stop_c) begin
      d.p     = 1'b1;
      d.s     = 1'b0;
      d.oe    = 1'b0;
      d.phase = isam_pkg::PH_IDLE;
      ev[isam_pkg::EV_STOP] = 1'b1;
    end
    ev[isam_pkg::EV_RX] = rx_set;

    // a flag set in the cycle of its clear stays set
    d.rx_holding_full = (q.rx_holding_full & ~rd_rx) | rx_set;
    d.tx_holding_full = (q.tx_holding_full & ~tx_done) | wr_tx;

    // ****************************************
    // register writes
    // ****************************************
    d.irqst = q.irqst;
    if (bus.wr) begin
      case (bus.addr)
        isam_pkg::OFS_MASK:    d.msk   = bus.wdata[9:0];
        isam_pkg::OFS_TXH:     d.txh   = bus.wdata[7:0];
        isam_pkg::OFS_SADDR:   d.saddr = bus.wdata[6:0];
        isam_pkg::OFS_CTRL:    d.en    = bus.wdata[isam_pkg::CTRL_EN];
        isam_pkg::OFS_IRQ_ST:  d.irqst = q.irqst & ~bus.wdata[isam_pkg::NEV-1:0];
        isam_pkg::OFS_IRQ_MSK: d.imsk  = bus.wdata[isam_pkg::NEV-1:0];
        default:               d.irqst = q.irqst;
      endcase
    end
    d.irqst = d.irqst | ev;
    d.irq   = |(d.irqst & d.imsk);

    // ****************************************
    // register reads, answered next cycle
    // ****************************************
    if (bus.rd) begin
      case (bus.addr)
        isam_pkg::OFS_STATUS: begin
          d.rdata[isam_pkg::ST_TBF]   = q.tx_holding_full;
          d.rdata[isam_pkg::ST_RBF]   = q.rx_holding_full;
          d.rdata[isam_pkg::ST_RW]    = q.rw;
          d.rdata[isam_pkg::ST_START] = q.s;
          d.rdata[isam_pkg::ST_STOP]  = q.p;
          d.rdata[isam_pkg::ST_DA]    = q.da;
          d.rdata[isam_pkg::ST_ACK]   = q.acknowledge_status_flag;
        end
        isam_pkg::OFS_MASK:    d.rdata = {6'h00, q.msk};
        isam_pkg::OFS_RXH:     d.rdata = {8'h00, q.rxh};
        isam_pkg::OFS_TXH:     d.rdata = {8'h00, q.txh};
        isam_pkg::OFS_SADDR:   d.rdata = {9'h000, q.saddr};
        isam_pkg::OFS_CTRL:    d.rdata = {15'h0000, q.en};
        isam_pkg::OFS_IRQ_ST:  d.rdata = {11'h000, q.irqst};
        isam_pkg::OFS_IRQ_MSK: d.rdata = {11'h000, q.imsk};
        default:               d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= RST_STATE;
    end else if (ce) begin
      q <= d;
    end
  end

  assign rdata   = q.rdata;
  assign irq     = q.irq;
  assign sda_out = q.drv;
  assign sda_oe  = q.oe;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || !ce);

  mask_read_a: assert property (
    bus.rd && bus.addr == isam_pkg::OFS_MASK |=> rdata[15:10] == 6'h00 && rdata[9:0] == q.msk)
    else $error("mask register read back wrong");
  start_flag_a: assert property (
    start_c |=> q.s && !q.p)
    else $error("start flag not set after start");
  stop_flag_a: assert property (
    stop_c |=> q.p && !q.s)
    else $error("stop flag not set after stop");
  rx_full_a: assert property (
    rx_set |=> q.rx_holding_full && q.da && q.rxh == $past(q.sh[6:0]) * 2 + $past(q.sda_s2))
    else $error("received byte not held");
  rx_clear_a: assert property (
    rd_rx && !rx_set |=> !q.rx_holding_full)
    else $error("reading holding register left flag set");
  tx_full_a: assert property (
    wr_tx |=> q.tx_holding_full && q.txh == $past(bus.wdata[7:0]))
    else $error("tx holding flag not set on write");
  tx_done_a: assert property (
    tx_done && !wr_tx |=> !q.tx_holding_full ##0 q.acknowledge_status_flag == $past(q.sda_s2))
    else $error("tx holding flag not cleared after byte");
  ack_hold_a: assert property (
    q.phase != isam_pkg::PH_MACK |=> $stable(q.acknowledge_status_flag))
    else $error("acknowledge status changed while not transmitting");
  addr_match_a: assert property (
    q.en && q.phase == isam_pkg::PH_ADDR && fall && q.bitcnt == isam_pkg::BYTE_BITS && match
    && !start_c && !stop_c |=> q.rw == $past(q.sh[0]) && !q.da && q.oe
    && q.phase == isam_pkg::PH_AACK)
    else $error("matched address not acknowledged");
  addr_miss_a: assert property (
    q.en && q.phase == isam_pkg::PH_ADDR && fall && q.bitcnt == isam_pkg::BYTE_BITS
    && !match && !start_c && !stop_c |=> q.phase == isam_pkg::PH_IDLE && !q.oe)
    else $error("unmatched address not ignored");

  // ****************************************
  // flags and rxh move only on their own events; mask write, direction and sda drive checks
  // ****************************************
  da_hold_a: assert property (
    !rx_set && !(q.phase == isam_pkg::PH_ADDR && fall) |=> $stable(q.da))
    else $error("data/address flag moved without a byte");
  rw_hold_a: assert property (
    !(q.phase == isam_pkg::PH_ADDR && fall) |=> $stable(q.rw))
    else $error("direction flag moved outside an address byte");
  cond_hold_a: assert property (
    !start_c && !stop_c |=> $stable(q.s) && $stable(q.p))
    else $error("start or stop flag moved without a bus condition");
  rbf_hold_a: assert property (
    !rx_set && !rd_rx |=> $stable(q.rx_holding_full))
    else $error("receive holding flag moved on its own");
  tbf_hold_a: assert property (
    !wr_tx && !tx_done |=> $stable(q.tx_holding_full))
    else $error("transmit holding flag moved on its own");
  rx_hold_a: assert property (
    q.phase != isam_pkg::PH_RX |=> $stable(q.rxh))
    else $error("receive holding register moved outside a data byte");
  mask_write_a: assert property (
    bus.wr && bus.addr == isam_pkg::OFS_MASK |=> q.msk == $past(bus.wdata[9:0]))
    else $error("mask register write lost");
  // a direction flip mid-frame would let the slave drive during a write
  dir_rx_a: assert property (
    q.phase == isam_pkg::PH_RX |-> !q.rw)
    else $error("slave receiving with read direction");
  dir_tx_a: assert property (
    q.phase == isam_pkg::PH_TX |-> q.rw)
    else $error("slave sending with write direction");
  tx_bit_a: assert property (
    q.en && q.phase == isam_pkg::PH_TX && fall && q.bitcnt != isam_pkg::BYTE_BITS
    |=> q.oe == !$past(q.txsh[7]))
    else $error("sent bit does not follow the held byte");
  oe_idle_a: assert property (
    q.phase == isam_pkg::PH_IDLE |=> !q.oe)
    else $error("line pulled while idle");
  ack_pull_a: assert property (
    q.en && q.phase == isam_pkg::PH_AACK && !fall && !start_c && !stop_c
    |=> q.oe && q.phase == isam_pkg::PH_AACK)
    else $error("acknowledge released early");

  match_c: cover property (q.phase == isam_pkg::PH_AACK && !q.rw);
  read_c:  cover property (tx_done ##[1:40] q.phase == isam_pkg::PH_TX);
  rx_c:    cover property (rx_set ##[1:40] rd_rx);
  stop_c_c: cover property (stop_c && q.irq);
  nak_end_c: cover property (tx_done ##1 q.acknowledge_status_flag);

endmodule
`default_nettype wire

// *** testbench/i2c_status_and_address_mask_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module i2c_status_and_address_mask_test;
  logic                mclk;
  logic                rst;
  logic                ce;
  isam_pkg::isam_bus_t bus;
  logic [15:0]         rdata;
  logic                irq;
  logic                scl;
  logic                m_sda;
  logic                sda_out;
  logic                sda_oe;
  wire                 sda_w;
  logic                a;
  logic [7:0]          d;
  int                  num_errors;
  int                  check_count;

  // open drain line with pull-up
  assign sda_w = (sda_oe ? sda_out : 1'b1) & m_sda;

  isam_status_mask u_dut (.mclk(mclk), .rst(rst), .ce(ce), .bus(bus),
    .rdata(rdata), .irq(irq), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe));

  isam_i2c_master u_mst (.scl(scl), .sda_o(m_sda), .sda(sda_w));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [4:0] ad, input logic [15:0] wd);
    @(posedge mclk);
    bus <= '{addr: ad, wdata: wd, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  task automatic rchk(input string n, input logic [4:0] ad, input logic [15:0] m,
                      input logic [15:0] e);
    @(posedge mclk);
    bus <= '{addr: ad, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 chk(n, e, rdata & m);
  endtask

  // irq is registered, so let two edges land first
  task automatic irq_is(input logic e);
    repeat (2) @(posedge mclk);
    #1 chk("irq", {15'h0000, e}, {15'h0000, irq});
  endtask

  task automatic frame(input logic [6:0] ad, input logic r, output logic ack);
    // keep pin moves off the clock edges
    #10;
    u_mst.start();
    u_mst.put_byte({ad, r}, ack);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #2000000;
    num_errors++;
    test_done();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    num_errors  = 0;
    check_count = 0;
    rst         = 1'b1;
    ce          = 1'b1;
    bus         = '0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rchk("status", isam_pkg::OFS_STATUS, 16'hFFFF, 16'h0000);
    rchk("mask", isam_pkg::OFS_MASK, 16'hFFFF, 16'h0000);
    wr(isam_pkg::OFS_MASK, 16'hFFFF);
    rchk("mask", isam_pkg::OFS_MASK, 16'hFFFF, 16'h03FF);
    // a write while the clock enable is low must be lost
    ce <= 1'b0;
    wr(isam_pkg::OFS_MASK, 16'h0155);
    ce <= 1'b1;
    rchk("mask frozen", isam_pkg::OFS_MASK, 16'hFFFF, 16'h03FF);
    rchk("unmapped", 5'h1E, 16'hFFFF, 16'h0000);
    wr(isam_pkg::OFS_CTRL, 16'h0001);
    wr(isam_pkg::OFS_IRQ_MSK, 16'h001F);
    // bits 9:7 set everywhere: with short addresses they must not help
    for (int i = 0; i < 7; i++) begin
      wr(isam_pkg::OFS_MASK, 16'h0380);
      frame(isam_pkg::SADDR_RST ^ (7'h01 << i), 1'b0, a);
      chk("nak", 16'h0000, {15'h0000, a});
      wr(isam_pkg::OFS_MASK, 16'h0380 | (16'h0001 << i));
      frame(isam_pkg::SADDR_RST ^ (7'h01 << i), 1'b0, a);
      chk("ack", 16'h0001, {15'h0000, a});
    end
    rchk("status", isam_pkg::OFS_STATUS, 16'hFFFF, 16'h0008);
    irq_is(1'b1);
    wr(isam_pkg::OFS_TXH, 16'h003C);
    rchk("status", isam_pkg::OFS_STATUS, 16'hFFFF, 16'h0009);
    frame(isam_pkg::SADDR_RST, 1'b1, a);
    chk("ack", 16'h0001, {15'h0000, a});
    rchk("status", isam_pkg::OFS_STATUS, 16'hFFFF, 16'h000D);
    u_mst.get_byte(1'b1, d);
    chk("tx byte", 16'h003C, {8'h00, d});
    rchk("status", isam_pkg::OFS_STATUS, 16'h801F, 16'h000C);
    u_mst.get_byte(1'b0, d);
    rchk("status", isam_pkg::OFS_STATUS, 16'h8001, 16'h8000);
    u_mst.stop();
    rchk("status", isam_pkg::OFS_STATUS, 16'h8018, 16'h8010);
    wr(isam_pkg::OFS_IRQ_MSK, 16'h0000);
    irq_is(1'b0);
    rchk("irq st", isam_pkg::OFS_IRQ_ST, 16'h001E, 16'h001E);
    wr(isam_pkg::OFS_IRQ_ST, 16'h001F);
    rchk("irq st", isam_pkg::OFS_IRQ_ST, 16'hFFFF, 16'h0000);
    wr(isam_pkg::OFS_IRQ_MSK, 16'h0001);
    // acknowledge status must survive a receive in which the device acks
    frame(isam_pkg::SADDR_RST, 1'b0, a);
    chk("ack", 16'h0001, {15'h0000, a});
    rchk("status", isam_pkg::OFS_STATUS, 16'hFFFF, 16'h8008);
    irq_is(1'b0);
    u_mst.put_byte(8'hA5, a);
    chk("data ack", 16'h0001, {15'h0000, a});
    rchk("status", isam_pkg::OFS_STATUS, 16'hFFFF, 16'h802A);
    irq_is(1'b1);
    rchk("rx hold", isam_pkg::OFS_RXH, 16'hFFFF, 16'h00A5);
    rchk("status", isam_pkg::OFS_STATUS, 16'h0002, 16'h0000);
    wr(isam_pkg::OFS_IRQ_ST, 16'h001F);
    irq_is(1'b0);
    u_mst.stop();
    rchk("status", isam_pkg::OFS_STATUS, 16'h0018, 16'h0010);
    rchk("tx hold", isam_pkg::OFS_TXH, 16'hFFFF, 16'h003C);
    rchk("ctrl", isam_pkg::OFS_CTRL, 16'hFFFF, 16'h0001);
    rchk("saddr", isam_pkg::OFS_SADDR, 16'hFFFF, {9'h000, isam_pkg::SADDR_RST});
    // a moved slave address with an exact mask
    wr(isam_pkg::OFS_MASK, 16'h0000);
    wr(isam_pkg::OFS_SADDR, 16'h0055);
    frame(7'h55, 1'b0, a);
    chk("ack new", 16'h0001, {15'h0000, a});
    frame(isam_pkg::SADDR_RST, 1'b0, a);
    chk("nak old", 16'h0000, {15'h0000, a});
    u_mst.stop();
    test_done();
  end
endmodule
`default_nettype wire

// *** testbench/isam_i2c_master.sv ***
`timescale 1ns/1ns
`default_nettype none
module isam_i2c_master (
  // link pins, 1 = released to the pull-up
  output logic      scl,
  output logic      sda_o,
  input  wire logic sda
);
  // bus idles high; the clock only moves inside a frame
  initial begin
    scl   = 1'b1;
    sda_o = 1'b1;
  end

  // also serves as repeated start when entered with scl low
  task automatic start();
    sda_o = 1'b1;
    #100 scl = 1'b1;
    #100 sda_o = 1'b0;
    #100 scl = 1'b0;
  endtask

  task automatic stop();
    #100 sda_o = 1'b0;
    #100 scl = 1'b1;
    #100 sda_o = 1'b1;
    #300;
  endtask

  // 400 ns bit: data moves mid low phase, sampled mid high phase
  task automatic send_bit(input logic b, output logic r);
    #100 sda_o = b;
    #100 scl = 1'b1;
    #100 r = sda;
    #100 scl = 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) send_bit(d[i], r);
    send_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic get_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      send_bit(1'b1, r);
      d[i] = r;
    end
    send_bit(~ack, r);
  endtask
endmodule
`default_nettype wire
